/* ebm_buffer_map.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ebm_params.svh"

// Operation
// - 64-byte shared control endpoint buffer at E740-E77F, read and write.
// - 64-byte endpoint one OUT buffer at E780-E7BF, read and write.
// - 64-byte endpoint one IN buffer at E7C0-E7FF, read and write.
// - Endpoint two window is 512 or 1024 bytes, read and write.
// - Endpoint four window is 512 bytes at F400-F5FF, read and write.
// - Endpoint six window is 512 or 1024 bytes, read and write.
// - Endpoint eight window is 512 bytes at FC00-FDFF, read and write.
module ebm_buffer_map
#(
  parameter int unsigned CPU_PERIOD_PS = `EBM_CPU_PERIOD_PS,
  parameter int unsigned IFC_PERIOD_PS = `EBM_IFC_PERIOD_PS
)
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire ebm_pkg::ebm_addr_type cpu_addr_i,
  input  wire ebm_pkg::ebm_byte_type cpu_wdata_i,
  input  wire logic                  cpu_wr_i,
  input  wire logic                  cpu_rd_i,
  input  wire logic                  ep2_size_1024_i,
  input  wire logic                  ep6_size_1024_i,
  input  wire logic                  sens_reg_sel_i,
  input  wire logic                  fault_clear_i,
  output ebm_pkg::ebm_byte_type      cpu_rdata_o,
  output logic                       cpu_rdata_valid_o,
  output logic                       cpu_hit_o,
  output logic                       sync_fault_wr_o,
  output logic                       sync_fault_rd_o
);
  import ebm_pkg::*;

  // ****************************************************************
  // Window table
  // ****************************************************************
  localparam ebm_addr_type BASE_TAB [EBM_NUM_WIN] = '{
    `EBM_CTRL_BASE,
    `EBM_EP1_OUT_BASE,
    `EBM_EP1_IN_BASE,
    `EBM_EP2_BASE,
    `EBM_EP4_BASE,
    `EBM_EP6_BASE,
    `EBM_EP8_BASE
  };

  // Storage depth is the largest size each window can take
  localparam int unsigned DEPTH_TAB [EBM_NUM_WIN] = '{
    `EBM_SMALL_BYTES,
    `EBM_SMALL_BYTES,
    `EBM_SMALL_BYTES,
    `EBM_LARGE_BYTES,
    `EBM_MID_BYTES,
    `EBM_LARGE_BYTES,
    `EBM_MID_BYTES
  };

  localparam logic [10:0] SIZE_SMALL = 11'(`EBM_SMALL_BYTES);
  localparam logic [10:0] SIZE_MID   = 11'(`EBM_MID_BYTES);
  localparam logic [10:0] SIZE_LARGE = 11'(`EBM_LARGE_BYTES);

  // ****************************************************************
  // Spacing figures
  // ****************************************************************
  // Ceiling of 3*(ifc+cpu) / (2*cpu), done in integers
  localparam int unsigned SYNC_CYCLES =
    (3 * (IFC_PERIOD_PS + CPU_PERIOD_PS) + 2 * CPU_PERIOD_PS - 1) / (2 * CPU_PERIOD_PS);
  localparam int unsigned MIN_GAP_INT = SYNC_CYCLES + `EBM_EXT_MOVE_CYCLES;
  localparam logic [`EBM_GAP_W-1:0] MIN_GAP = `EBM_GAP_W'(MIN_GAP_INT);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [10:0]          win_size  [EBM_NUM_WIN];
  ebm_addr_type         win_off   [EBM_NUM_WIN];
  logic [EBM_NUM_WIN-1:0] win_hit;
  ebm_byte_type         win_rdata [EBM_NUM_WIN];

  always_comb
  begin
    win_size[EBM_WIN_CTRL]    = SIZE_SMALL;
    win_size[EBM_WIN_EP1_OUT] = SIZE_SMALL;
    win_size[EBM_WIN_EP1_IN]  = SIZE_SMALL;
    win_size[EBM_WIN_EP2]     = ep2_size_1024_i ? SIZE_LARGE : SIZE_MID;
    win_size[EBM_WIN_EP4]     = SIZE_MID;
    win_size[EBM_WIN_EP6]     = ep6_size_1024_i ? SIZE_LARGE : SIZE_MID;
    win_size[EBM_WIN_EP8]     = SIZE_MID;
  end

  // ****************************************************************
  // Buffers, one per window
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < EBM_NUM_WIN; gi++)
    begin : g_win
      localparam int unsigned DEPTH = DEPTH_TAB[gi];
      localparam int unsigned AW    = $clog2(DEPTH);

      // Byte n of the buffer sits at base plus n
      assign win_off[gi] = cpu_addr_i - BASE_TAB[gi];
      assign win_hit[gi] = (cpu_addr_i >= BASE_TAB[gi]) &&
                           (win_off[gi] < {5'h00, win_size[gi]});

      ebm_byte_ram
      #(
        .DEPTH (DEPTH),
        .AW    (AW)
      )
      u_ram
      (
        .core_clk_i (core_clk_i),
        .wr_en_i    (cpu_wr_i & win_hit[gi]),
        .addr_i     (win_off[gi][AW-1:0]),
        .wdata_i    (cpu_wdata_i),
        .rdata_o    (win_rdata[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  ebm_byte_type rdata_d;
  ebm_byte_type rdata_q;
  logic         rvalid_d;
  logic         rvalid_q;
  logic         hit_d;
  logic         hit_q;

  // Last read byte, held until the next read
  always_comb
  begin
    // Unmapped reads return zero so the bus never floats
    rdata_d = 8'h00;
    for (int i = 0; i < EBM_NUM_WIN; i++)
    begin
      if (cpu_rd_i && win_hit[i])
      begin
        rdata_d = win_rdata[i];
      end
    end
    if (!cpu_rd_i)
    begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Strobe echoes, one cycle each
  always_comb
  begin
    rvalid_d = cpu_rd_i;
    hit_d    = (cpu_rd_i | cpu_wr_i) & (|win_hit);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      hit_q    <= hit_d;
    end
  end

  assign cpu_rdata_o       = rdata_q;
  assign cpu_rdata_valid_o = rvalid_q;
  assign cpu_hit_o         = hit_q;

  // ****************************************************************
  // Spacing watch
  // ****************************************************************
  // Firmware owns the spacing; this only flags a short gap so a
  // lost write or stale read can be traced, it never stalls the CPU.
  logic                    page_acc;
  logic                    page_wr;
  logic                    page_rd;
  logic                    sens_wr;
  logic [`EBM_GAP_W-1:0]   page_gap_d;
  logic [`EBM_GAP_W-1:0]   page_gap_q;
  logic [`EBM_GAP_W-1:0]   sens_gap_d;
  logic [`EBM_GAP_W-1:0]   sens_gap_q;
  logic                    page_armed_d;
  logic                    page_armed_q;
  logic                    sens_armed_d;
  logic                    sens_armed_q;
  logic                    fault_wr_d;
  logic                    fault_wr_q;
  logic                    fault_rd_d;
  logic                    fault_rd_q;
  logic                    short_wr;
  logic                    short_rd;

  // Strobe decode, shared by the counters and the flags
  always_comb
  begin
    page_acc = (cpu_addr_i[15:8] == `EBM_REG_PAGE);
    page_wr  = cpu_wr_i & page_acc;
    page_rd  = cpu_rd_i & page_acc;
    // Sensitive membership is decoded by the register file owner
    sens_wr  = cpu_wr_i & sens_reg_sel_i;
  end

  // Cycles since the last register page write, saturating
  always_comb
  begin
    page_gap_d   = (page_gap_q < MIN_GAP) ? page_gap_q + 1'b1 : page_gap_q;
    page_armed_d = page_armed_q;
    if (page_wr)
    begin
      page_gap_d   = '0;
      page_armed_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      page_gap_q   <= '0;
      page_armed_q <= 1'b0;
    end
    else
    begin
      page_gap_q   <= page_gap_d;
      page_armed_q <= page_armed_d;
    end
  end

  // Cycles since the last sensitive write, saturating
  always_comb
  begin
    sens_gap_d   = (sens_gap_q < MIN_GAP) ? sens_gap_q + 1'b1 : sens_gap_q;
    sens_armed_d = sens_armed_q;
    if (sens_wr)
    begin
      sens_gap_d   = '0;
      sens_armed_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sens_gap_q   <= '0;
      sens_armed_q <= 1'b0;
    end
    else
    begin
      sens_gap_q   <= sens_gap_d;
      sens_armed_q <= sens_armed_d;
    end
  end

  // Sticky fault flags
  always_comb
  begin
    // Strobe k cycles after the write sees a count of k-1
    short_wr = page_armed_q && sens_wr && ((page_gap_q + 1'b1) < MIN_GAP);
    short_rd = sens_armed_q && page_rd && ((sens_gap_q + 1'b1) < MIN_GAP);
    // Other orderings are never flagged; a new event beats a clear
    fault_wr_d = (fault_wr_q & ~fault_clear_i) | short_wr;
    fault_rd_d = (fault_rd_q & ~fault_clear_i) | short_rd;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      fault_wr_q <= 1'b0;
      fault_rd_q <= 1'b0;
    end
    else
    begin
      fault_wr_q <= fault_wr_d;
      fault_rd_q <= fault_rd_d;
    end
  end

  assign sync_fault_wr_o = fault_wr_q;
  assign sync_fault_rd_o = fault_rd_q;

endmodule : ebm_buffer_map

`default_nettype wire

/* ebm_params.svh */
`ifndef EBM_PARAMS_SVH
`define EBM_PARAMS_SVH

// ****************************************************************
// Buffer window bases (CPU external data space)
// ****************************************************************
`define EBM_CTRL_BASE        16'hE740
`define EBM_EP1_OUT_BASE     16'hE780
`define EBM_EP1_IN_BASE      16'hE7C0
`define EBM_EP2_BASE         16'hF000
`define EBM_EP4_BASE         16'hF400
`define EBM_EP6_BASE         16'hF800
`define EBM_EP8_BASE         16'hFC00

// ****************************************************************
// Buffer sizes in bytes
// ****************************************************************
`define EBM_SMALL_BYTES      64
`define EBM_MID_BYTES        512
`define EBM_LARGE_BYTES      1024

// ****************************************************************
// Register page that the spacing checks watch
// ****************************************************************
`define EBM_REG_PAGE         8'hE6

// ****************************************************************
// Spacing timing
// ****************************************************************
`define EBM_EXT_MOVE_CYCLES  2
`define EBM_CPU_PERIOD_PS    10000
`define EBM_IFC_PERIOD_PS    20800
`define EBM_GAP_W            16

`endif

/* ebm_pkg.sv */
`default_nettype none
package ebm_pkg;

  typedef logic [15:0] ebm_addr_type;
  typedef logic [7:0]  ebm_byte_type;

  // Endpoint window index, also the order of the buffer instances
  typedef enum int unsigned
  {
    EBM_WIN_CTRL    = 0,
    EBM_WIN_EP1_OUT = 1,
    EBM_WIN_EP1_IN  = 2,
    EBM_WIN_EP2     = 3,
    EBM_WIN_EP4     = 4,
    EBM_WIN_EP6     = 5,
    EBM_WIN_EP8     = 6
  } ebm_win_type;

  localparam int unsigned EBM_NUM_WIN = 7;

endpackage : ebm_pkg

`default_nettype wire

/* ebm_byte_ram.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Byte-wide buffer, synchronous write, combinational read
// ****************************************************************
module ebm_byte_ram
#(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = 6
)
(
  input  wire logic                  core_clk_i,
  input  wire logic                  wr_en_i,
  input  wire logic [AW-1:0]         addr_i,
  input  wire ebm_pkg::ebm_byte_type wdata_i,
  output ebm_pkg::ebm_byte_type      rdata_o
);
  import ebm_pkg::*;

  // No reset on purpose: contents are undefined until written
  ebm_byte_type mem_q [DEPTH];

  always_ff @(posedge core_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[addr_i];

endmodule : ebm_byte_ram

`default_nettype wire

/* ebm_buffer_map_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Window decode and strobe spacing checks
// ****
module ebm_buffer_map_props
#(
  parameter int unsigned CPU_PERIOD_PS = 10000,
  parameter int unsigned IFC_PERIOD_PS = 20800
)
(
  input wire logic                  core_clk_i,
  input wire logic                  rst_i,
  input wire ebm_pkg::ebm_addr_type cpu_addr_i,
  input wire ebm_pkg::ebm_byte_type cpu_wdata_i,
  input wire logic                  cpu_wr_i,
  input wire logic                  cpu_rd_i,
  input wire logic                  ep2_size_1024_i,
  input wire logic                  ep6_size_1024_i,
  input wire logic                  sens_reg_sel_i,
  input wire logic                  fault_clear_i,
  input wire ebm_pkg::ebm_byte_type cpu_rdata_o,
  input wire logic                  cpu_rdata_valid_o,
  input wire logic                  cpu_hit_o,
  input wire logic                  sync_fault_wr_o,
  input wire logic                  sync_fault_rd_o
);
  import ebm_pkg::*;
  localparam int unsigned GAP = (3*(IFC_PERIOD_PS+CPU_PERIOD_PS)+2*CPU_PERIOD_PS-1)/(2*CPU_PERIOD_PS)+2;
  logic [7:0] wa_q, wa_d, sa_q, sa_d;
  logic       pg, acc, sw;
  assign pg  = cpu_addr_i[15:8] == 8'hE6;
  assign acc = cpu_wr_i | cpu_rd_i;
  assign sw  = cpu_wr_i & sens_reg_sel_i;
  // Saturating, so an old arm never wraps into a false fault
  always_comb
  begin
    wa_d = (wa_q == 8'hFF) ? wa_q : wa_q + 8'h01;
    sa_d = (sa_q == 8'hFF) ? sa_q : sa_q + 8'h01;
    if (cpu_wr_i && pg)
      wa_d = 8'h01;
    if (sw)
      sa_d = 8'h01;
  end
  always_ff @(posedge core_clk_i)
  begin
    wa_q <= rst_i ? 8'hFF : wa_d;
    sa_q <= rst_i ? 8'hFF : sa_d;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_read_answer: assert property (cpu_rd_i |=> cpu_rdata_valid_o) else $error("read not answered");
  chk_valid_cause: assert property (cpu_rdata_valid_o |-> $past(cpu_rd_i)) else $error("stray valid");
  chk_small_hit: assert property (acc && cpu_addr_i inside {[16'hE740:16'hE7FF]} |=> cpu_hit_o)
    else $error("small window missed");
  chk_ep4_hit: assert property (acc && cpu_addr_i inside {[16'hF400:16'hF5FF]} |=> cpu_hit_o)
    else $error("ep4 window missed");
  chk_ep8_hit: assert property (acc && cpu_addr_i inside {[16'hFC00:16'hFDFF]} |=> cpu_hit_o)
    else $error("ep8 window missed");
  chk_ep2_size: assert property (acc && cpu_addr_i inside {[16'hF200:16'hF3FF]} |=>
    cpu_hit_o == $past(ep2_size_1024_i)) else $error("ep2 size decode");
  chk_ep6_size: assert property (acc && cpu_addr_i inside {[16'hFA00:16'hFBFF]} |=>
    cpu_hit_o == $past(ep6_size_1024_i)) else $error("ep6 size decode");
  chk_miss_zero: assert property (cpu_rdata_valid_o && !cpu_hit_o |-> cpu_rdata_o == 8'h00)
    else $error("miss read not zero");
  chk_wr_gap: assert property (sw && wa_q < GAP |=> sync_fault_wr_o) else $error("early write unflagged");
  chk_rd_gap: assert property (cpu_rd_i && pg && sa_q < GAP |=> sync_fault_rd_o)
    else $error("early read unflagged");
  chk_wr_quiet: assert property (!sync_fault_wr_o && !(sw && wa_q < GAP) |=> !sync_fault_wr_o)
    else $error("write fault without cause");
  chk_wr_sticky: assert property (sync_fault_wr_o && !fault_clear_i |=> sync_fault_wr_o)
    else $error("write fault dropped");
  chk_rd_quiet: assert property (!sync_fault_rd_o && !(cpu_rd_i && pg && sa_q < GAP) |=> !sync_fault_rd_o)
    else $error("read fault without cause");
  chk_rd_sticky: assert property (sync_fault_rd_o && !fault_clear_i |=> sync_fault_rd_o)
    else $error("read fault dropped");
endmodule : ebm_buffer_map_props

bind ebm_buffer_map ebm_buffer_map_props #(.CPU_PERIOD_PS(CPU_PERIOD_PS), .IFC_PERIOD_PS(IFC_PERIOD_PS)) u_props
(
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
  .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .ep2_size_1024_i(ep2_size_1024_i),
  .ep6_size_1024_i(ep6_size_1024_i), .sens_reg_sel_i(sens_reg_sel_i), .fault_clear_i(fault_clear_i),
  .cpu_rdata_o(cpu_rdata_o), .cpu_rdata_valid_o(cpu_rdata_valid_o), .cpu_hit_o(cpu_hit_o),
  .sync_fault_wr_o(sync_fault_wr_o), .sync_fault_rd_o(sync_fault_rd_o)
);
`default_nettype wire

/* ebm_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Firmware side: one strobe per external data move
// ****
module ebm_cpu_model
#(
  parameter int unsigned CPU_PS = 10000,
  parameter int unsigned IFC_PS = 20800
)
(
  input  wire logic                  core_clk_i,
  output ebm_pkg::ebm_addr_type      addr_o,
  output ebm_pkg::ebm_byte_type      wdata_o,
  output logic                       wr_o,
  output logic                       rd_o,
  output logic                       sens_o,
  input  wire ebm_pkg::ebm_byte_type rdata_i,
  input  wire logic                  valid_i,
  input  wire logic                  hit_i
);
  import ebm_pkg::*;
  localparam int unsigned SYNC = (3*(IFC_PS+CPU_PS)+2*CPU_PS-1)/(2*CPU_PS);
  ebm_byte_type rq;
  logic         vq;
  logic         hq;
  initial
  begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    sens_o = 1'b0;
  end
  // Two bus cycles per move; idle address and data show the complement, not a stale copy, and the strobes go low
  task automatic acc(input logic w, input ebm_addr_type a, input ebm_byte_type d, input logic s);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    sens_o <= s;
    @(posedge core_clk_i);
    addr_o <= ~a;
    wdata_o <= ~d;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    sens_o <= 1'b0;
    #1;
    rq = rdata_i;
    vq = valid_i;
    hq = hit_i;
  endtask : acc
  task automatic idle(input int unsigned n);
    repeat (n) @(posedge core_clk_i);
  endtask : idle
  task automatic sync_wait;
    idle(SYNC);
  endtask : sync_wait
endmodule : ebm_cpu_model
`default_nettype wire

/* endpoint_buffer_map_sync_delay_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ebm_params.svh"
module endpoint_buffer_map_sync_delay_tb;
  import ebm_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         ep2_sz = 1'b1;
  logic         ep6_sz = 1'b1;
  logic         clr = 1'b0;
  logic         wr, rd, sens, valid, hit, fwr, frd;
  ebm_addr_type addr;
  ebm_byte_type wdata, rdata;
  int           miscompares = 0;
  int           samples_checked = 0;
  int           cyc = 0;
  localparam ebm_addr_type BASE [7] = '{`EBM_CTRL_BASE, `EBM_EP1_OUT_BASE, `EBM_EP1_IN_BASE,
    `EBM_EP2_BASE, `EBM_EP4_BASE, `EBM_EP6_BASE, `EBM_EP8_BASE};
  localparam int SIZE [7] = '{`EBM_SMALL_BYTES, `EBM_SMALL_BYTES, `EBM_SMALL_BYTES,
    `EBM_LARGE_BYTES, `EBM_MID_BYTES, `EBM_LARGE_BYTES, `EBM_MID_BYTES};
  always #5 core_clk = ~core_clk;
  ebm_buffer_map DUT (.core_clk_i(core_clk), .rst_i(rst), .cpu_addr_i(addr), .cpu_wdata_i(wdata),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .ep2_size_1024_i(ep2_sz), .ep6_size_1024_i(ep6_sz),
    .sens_reg_sel_i(sens), .fault_clear_i(clr), .cpu_rdata_o(rdata), .cpu_rdata_valid_o(valid),
    .cpu_hit_o(hit), .sync_fault_wr_o(fwr), .sync_fault_rd_o(frd));
  ebm_cpu_model cpu (.core_clk_i(core_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .sens_o(sens), .rdata_i(rdata), .valid_i(valid), .hit_i(hit));
  task automatic chk8(input ebm_byte_type g, input ebm_byte_type e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk1
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // All writes first, so one window aliasing another shows up
  task automatic t_windows;
    for (int i = 0; i < 7; i++)
    begin
      cpu.acc(1'b1, BASE[i], ebm_byte_type'(8'h10 + i), 1'b0);
      cpu.acc(1'b1, ebm_addr_type'(BASE[i] + SIZE[i] - 1), ebm_byte_type'(8'h80 + i), 1'b0);
    end
    for (int i = 0; i < 7; i++)
    begin
      cpu.acc(1'b0, BASE[i], 8'h00, 1'b0);
      chk1(cpu.hq & cpu.vq, 1'b1, "first hit");
      chk8(cpu.rq, ebm_byte_type'(8'h10 + i), "first byte");
      cpu.acc(1'b0, ebm_addr_type'(BASE[i] + SIZE[i] - 1), 8'h00, 1'b0);
      chk8(cpu.rq, ebm_byte_type'(8'h80 + i), "last byte");
    end
    $display("test windows done");
  endtask : t_windows
  task automatic t_refuse;
    ebm_addr_type a [4] = '{16'hF200, 16'hFBFF, 16'hE800, 16'hE73F};
    @(posedge core_clk);
    ep2_sz <= 1'b0;
    ep6_sz <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      cpu.acc(1'b0, a[i], 8'h00, 1'b0);
      chk1(cpu.hq, 1'b0, "miss hit");
      chk8(cpu.rq, 8'h00, "miss data");
    end
    @(posedge core_clk);
    ep2_sz <= 1'b1;
    ep6_sz <= 1'b1;
    $display("test refuse done");
  endtask : t_refuse
  task automatic pulse_clr;
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    #1;
    chk1(fwr | frd, 1'b0, "cleared");
  endtask : pulse_clr
  task automatic t_gap;
    cpu.acc(1'b1, 16'hE600, 8'h01, 1'b0);
    cpu.idle(cpu.SYNC - 1);
    cpu.acc(1'b1, 16'hE610, 8'h02, 1'b1);
    chk1(fwr, 1'b1, "early write");
    pulse_clr();
    cpu.acc(1'b1, 16'hE600, 8'h03, 1'b0);
    cpu.sync_wait();
    cpu.acc(1'b1, 16'hE610, 8'h04, 1'b1);
    chk1(fwr, 1'b0, "spaced write");
    cpu.idle(cpu.SYNC - 1);
    cpu.acc(1'b0, 16'hE620, 8'h00, 1'b0);
    chk1(frd, 1'b1, "early read");
    pulse_clr();
    cpu.acc(1'b1, 16'hE611, 8'h05, 1'b1);
    cpu.sync_wait();
    cpu.acc(1'b0, 16'hE620, 8'h00, 1'b0);
    cpu.acc(1'b1, 16'hE601, 8'h06, 1'b0);
    cpu.acc(1'b1, 16'hE602, 8'h07, 1'b0);
    cpu.acc(1'b0, 16'hE603, 8'h00, 1'b0);
    chk1(fwr | frd, 1'b0, "free order");
    $display("test gap done");
  endtask : t_gap
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      $display("mismatch %0t timeout", $time);
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_windows();
    t_refuse();
    t_gap();
    end_sim();
  end
endmodule : endpoint_buffer_map_sync_delay_tb
`default_nettype wire
